// ==== alu_core_pkg.sv ====
// Shared constants, register map and types of the integer datapath
`default_nettype none
package alu_core_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses on the register bus)
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] OFF_FLAGS     = 12'h000; // Flags and priority
    localparam logic [11:0] OFF_CORE_CTL  = 12'h004; // Core control
    localparam logic [11:0] OFF_INT_CTL1  = 12'h008; // Interrupt control one
    localparam logic [11:0] OFF_TBL_PAGE  = 12'h00c; // Table page register
    localparam logic [11:0] OFF_PC        = 12'h010; // Program counter view
    localparam logic [11:0] OFF_WREG_BASE = 12'h040; // Working registers 0..15
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FLG_DC     = 8;
    localparam int FLG_IPL_HI = 7;
    localparam int FLG_IPL_LO = 5;
    localparam int FLG_RA     = 4;
    localparam int FLG_N      = 3;
    localparam int FLG_OV     = 2;
    localparam int FLG_Z      = 1;
    localparam int FLG_C      = 0;
    localparam int CTL_PRIORITY_EXTENSION_BIT   = 3;
    localparam int CTL_PSV    = 2;
    localparam int ICTL_NEST  = 15;
    localparam int TBL_CFG    = 7;
    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [23:0] RST_PC     = 24'h000000;
    localparam logic [23:0] PC_STEP    = 24'h000002;
    localparam logic [4:0]  DIV_ITER   = 5'h10;     // One per divisor bit
    localparam int          DIV_CYCLES = 19;        // Accept edge to done
    localparam logic [2:0]  IPL_MAX    = 3'h7;
    // ------------------------------------------------------------
    // Operations, multiply modes, divider states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
        OP_ARS, OP_LRS, OP_LSH, OP_MUL, OP_DIV
    } op_t;
    typedef enum logic [2:0] {
        MUL_SS, MUL_UU, MUL_SU, MUL_US, MUL_SLIT, MUL_ULIT, MUL_BB
    } mul_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE, ST_DIV_RUN, ST_DIV_FIX, ST_DIV_WB
    } div_state_t;
endpackage
`default_nettype wire

// ==== cpu_alu_status_datapath.sv ====
// Integer datapath: ALU, flags/priority, multiplier, divider, shifter, PC
//
// The register offsets and register access over APB were decided locally.
`default_nettype none
module cpu_alu_status_datapath
    import alu_core_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    // APB register slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic [3:0]        i_pstrb,
    output logic                   o_pready,
    output logic [31:0]            o_prdata,
    output logic                   o_pslverr,
    // Operation request
    input  wire logic              i_op_valid,
    input  wire op_t               i_op,
    input  wire mul_mode_t         i_mul_mode,
    input  wire logic              i_byte_mode,
    input  wire logic              i_src_mem,
    input  wire logic              i_dst_mem,
    input  wire logic              i_use_lit,
    input  wire logic [4:0]        i_lit,
    input  wire logic [3:0]        i_wa,
    input  wire logic [3:0]        i_wb,
    input  wire logic [3:0]        i_wd,
    input  wire logic              i_div_signed,
    input  wire logic              i_div_long,
    input  wire logic              i_div_hold,
    input  wire logic [15:0]       i_mem_rdata,
    // Core status inputs
    input  wire logic              i_repeat_active,
    input  wire logic              i_ipl_load,
    input  wire logic [2:0]        i_ipl_value,
    input  wire logic              i_priority_ext_set,
    // Program space
    input  wire logic              i_pc_advance,
    input  wire logic              i_pc_load,
    input  wire logic [23:0]       i_pc_target,
    input  wire logic [23:0]       i_prog_addr,
    input  wire logic              i_table_op,
    // Results
    output logic                   o_busy,
    output logic                   o_done,
    output logic [15:0]            o_result,
    output logic                   o_mem_we,
    output logic                   o_mem_byte,
    output logic [15:0]            o_mem_wdata,
    // Core status outputs
    output logic [3:0]             o_cpu_priority,
    output logic                   o_user_irq_disable,
    output logic                   o_psv_map_enable,
    output logic [23:0]            o_pc,
    output logic                   o_prog_access_ok
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0][15:0] wreg;       // Working register array
        logic              dc, n, ov, z, c, ra;
        logic [2:0]        ipl;        // Status priority field
        logic              priority_extension_bit, program_visibility_enable, nest_dis;
        logic [7:0]        table_page_register;
        logic [23:0]       pc;
        logic              prog_ok, irq_off;
        logic [3:0]        prio;
        div_state_t        st;
        logic              busy;       // Divider running, registered copy of state
        logic [4:0]        cnt;
        logic [16:0]       rem;        // Partial remainder
        logic [15:0]       quo;        // Dividend low / quotient shifter
        logic [15:0]       dvs;        // Divisor magnitude
        logic              qneg, rneg;
        logic [15:0]       result;
        logic              done, mem_we, mem_byte;
        logic [15:0]       mem_wdata;
        logic              pready, pslverr;
        logic [31:0]       prdata;
    } state_t;

    state_t s_r;   // Registered state
    state_t s_nxt; // Next state

    // Register-bus view of the flags word, unimplemented bits zero
    logic [15:0] flags_view;
    assign flags_view = {7'h00, s_r.dc, s_r.ipl, s_r.ra, s_r.n, s_r.ov, s_r.z, s_r.c};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] a, b, bx, res, m, wd, rd;
        logic [16:0] sw, t;
        logic [8:0]  sb;
        logic [4:0]  nib;
        logic [3:0]  sc, de;
        logic        cin, hit, fire, multi, sa, sb_s;
        logic [16:0] ma, mb;
        logic signed [33:0] prod;
        logic [31:0] dvd, mag;
        a = RST_WORD; b = RST_WORD; bx = RST_WORD; res = RST_WORD;
        m = RST_WORD; wd = RST_WORD; rd = RST_WORD;
        sw = '0; t = '0; sb = '0; nib = '0; sc = '0; de = '0;
        cin = 1'b0; hit = 1'b0; fire = 1'b0; multi = 1'b0; sa = 1'b0; sb_s = 1'b0;
        ma = '0; mb = '0; prod = '0; dvd = '0; mag = '0;
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.mem_we = 1'b0;
        s_nxt.pready = 1'b0;
        s_nxt.ra = i_repeat_active;
        // Register read decode
        hit = 1'b1;
        if (i_paddr == OFF_FLAGS) rd = flags_view;
        else if (i_paddr == OFF_CORE_CTL) rd = {12'h000, s_r.priority_extension_bit, s_r.program_visibility_enable, 2'b00};
        else if (i_paddr == OFF_INT_CTL1) rd = {s_r.nest_dis, 15'h0000};
        else if (i_paddr == OFF_TBL_PAGE) rd = {8'h00, s_r.table_page_register};
        else if (i_paddr[11:6] == OFF_WREG_BASE[11:6]) rd = s_r.wreg[i_paddr[5:2]];
        else hit = 1'b0;
        // Setup cycle: answer captured so access phase sees registered data
        if (i_psel && !i_penable && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = (i_paddr == OFF_PC) ? {8'h00, s_r.pc} : {16'h0000, rd};
            s_nxt.pslverr = !hit && (i_paddr != OFF_PC);
        end
        // Write takes effect at the access edge; byte lanes 0 and 1 only
        m = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
        wd = (rd & ~m) | (i_pwdata[15:0] & m);
        if (i_psel && i_penable && s_r.pready && i_pwrite && !s_r.pslverr) begin
            if (i_paddr == OFF_FLAGS) begin
                s_nxt.dc = wd[FLG_DC];
                s_nxt.n  = wd[FLG_N];
                s_nxt.ov = wd[FLG_OV];
                s_nxt.z  = wd[FLG_Z];
                s_nxt.c  = wd[FLG_C];
                if (!s_r.nest_dis)
                    s_nxt.ipl = wd[FLG_IPL_HI:FLG_IPL_LO];
            end else if (i_paddr == OFF_CORE_CTL) begin
                if (!wd[CTL_PRIORITY_EXTENSION_BIT])
                    s_nxt.priority_extension_bit = 1'b0;
                s_nxt.program_visibility_enable = wd[CTL_PSV];
            end else if (i_paddr == OFF_INT_CTL1) begin
                s_nxt.nest_dis = wd[ICTL_NEST];
            end else if (i_paddr == OFF_TBL_PAGE) begin
                s_nxt.table_page_register = wd[7:0];
            end else if (i_paddr[11:6] == OFF_WREG_BASE[11:6]) begin
                s_nxt.wreg[i_paddr[5:2]] = wd;
            end
        end
        // Hardware priority updates win over software in the same cycle
        if (i_ipl_load)
            s_nxt.ipl = i_ipl_value;
        if (i_priority_ext_set)
            s_nxt.priority_extension_bit = 1'b1;
        // Operand fetch from registers or data memory
        a = i_src_mem ? i_mem_rdata : s_r.wreg[i_wa];
        b = i_use_lit ? {11'h000, i_lit} : s_r.wreg[i_wb];
        sc = i_lit[3:0];
        multi = (i_op inside {OP_ARS, OP_LRS, OP_LSH}) && (sc != 4'h1);
        if (multi)
            a = s_r.wreg[i_wa];
        cin = (i_op == OP_SUB);
        bx = cin ? ~b : b;
        sw = {1'b0, a} + {1'b0, bx} + {16'h0000, cin};
        sb = {1'b0, a[7:0]} + {1'b0, bx[7:0]} + {8'h00, cin};
        nib = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
        fire = i_op_valid && (s_r.st == ST_IDLE);
        if (fire && i_op != OP_DIV && i_op != OP_MUL) begin
            unique case (i_op)
                OP_ADD, OP_SUB: begin
                    res = i_byte_mode ? {8'h00, sb[7:0]} : sw[15:0];
                    s_nxt.c  = i_byte_mode ? sb[8] : sw[16];
                    s_nxt.dc = i_byte_mode ? nib[4] : sb[8];
                    s_nxt.ov = i_byte_mode ? (a[7] == bx[7]) && (res[7] != a[7])
                                           : (a[15] == bx[15]) && (res[15] != a[15]);
                end
                OP_AND: res = a & b;
                OP_IOR: res = a | b;
                OP_XOR: res = a ^ b;
                OP_ARS: begin
                    res = i_byte_mode ? {8'h00, 8'($signed(a[7:0]) >>> sc)}
                                      : 16'($signed(a) >>> sc);
                    if (sc == 4'h1) s_nxt.c = a[0];
                end
                OP_LRS: begin
                    res = i_byte_mode ? {8'h00, 8'(a[7:0] >> sc)} : 16'(a >> sc);
                    if (sc == 4'h1) s_nxt.c = a[0];
                end
                default: begin
                    res = i_byte_mode ? {8'h00, 8'(a[7:0] << sc)} : 16'(a << sc);
                    if (sc == 4'h1) s_nxt.c = i_byte_mode ? a[7] : a[15];
                end
            endcase
            if (i_byte_mode) res = {8'h00, res[7:0]};
            s_nxt.n = i_byte_mode ? res[7] : res[15];
            s_nxt.z = i_byte_mode ? (res[7:0] == 8'h00) : (res == 16'h0000);
            s_nxt.result = res;
            s_nxt.done = 1'b1;
            if (i_dst_mem && !multi) begin
                s_nxt.mem_we = 1'b1;
                s_nxt.mem_byte = i_byte_mode;
                s_nxt.mem_wdata = res;
            end else if (i_byte_mode) begin
                s_nxt.wreg[i_wd][7:0] = res[7:0];
            end else begin
                s_nxt.wreg[i_wd] = res;
            end
        end
        // Multiplier: flags are left alone
        if (fire && i_op == OP_MUL) begin
            sa   = (i_mul_mode inside {MUL_SS, MUL_SU, MUL_SLIT}) && a[15];
            sb_s = (i_mul_mode inside {MUL_SS, MUL_US}) && b[15];
            ma = (i_mul_mode == MUL_BB) ? {9'h000, a[7:0]} : {sa, a};
            mb = (i_mul_mode == MUL_BB) ? {9'h000, b[7:0]}
               : (i_mul_mode inside {MUL_SLIT, MUL_ULIT}) ? {12'h000, i_lit}
               : {sb_s, b};
            prod = $signed(ma) * $signed(mb);
            s_nxt.result = prod[15:0];
            s_nxt.done = 1'b1;
            if (i_mul_mode == MUL_BB) begin
                s_nxt.wreg[i_wd] = prod[15:0];
            end else begin
                s_nxt.wreg[{i_wd[3:1], 1'b0}] = prod[15:0];
                s_nxt.wreg[{i_wd[3:1], 1'b1}] = prod[31:16];
            end
        end
        // Divider: load magnitudes, 16 iterations, sign fix, write back
        if (fire && i_op == OP_DIV) begin
            de = {i_wa[3:1], 1'b0};
            dvd = i_div_long ? {s_r.wreg[de | 4'h1], s_r.wreg[de]}
                : {{16{i_div_signed & s_r.wreg[i_wa][15]}}, s_r.wreg[i_wa]};
            sa   = i_div_signed && dvd[31];
            sb_s = i_div_signed && s_r.wreg[i_wb][15];
            mag = sa ? 32'(-dvd) : dvd;
            s_nxt.dvs = sb_s ? 16'(-s_r.wreg[i_wb]) : s_r.wreg[i_wb];
            s_nxt.rem = {1'b0, mag[31:16]};
            s_nxt.quo = mag[15:0];
            s_nxt.qneg = sa ^ sb_s;
            s_nxt.rneg = sa;
            s_nxt.cnt = 5'h00;
            s_nxt.st = ST_DIV_RUN;
        end
        // Hold freezes the divider so an interrupt can be taken between cycles
        if (!i_div_hold) begin
            unique case (s_r.st)
                ST_IDLE: ;
                ST_DIV_RUN: begin
                    t = {s_r.rem[15:0], s_r.quo[15]};
                    if (t >= {1'b0, s_r.dvs}) begin
                        s_nxt.rem = t - {1'b0, s_r.dvs};
                        s_nxt.quo = {s_r.quo[14:0], 1'b1};
                    end else begin
                        s_nxt.rem = t;
                        s_nxt.quo = {s_r.quo[14:0], 1'b0};
                    end
                    s_nxt.cnt = s_r.cnt + 5'h01;
                    if (s_r.cnt == DIV_ITER - 5'h01)
                        s_nxt.st = ST_DIV_FIX;
                end
                ST_DIV_FIX: begin
                    if (s_r.qneg) s_nxt.quo = 16'(-s_r.quo);
                    if (s_r.rneg) s_nxt.rem = {1'b0, 16'(-s_r.rem[15:0])};
                    s_nxt.st = ST_DIV_WB;
                end
                ST_DIV_WB: begin
                    s_nxt.wreg[0] = s_r.quo;
                    s_nxt.wreg[1] = s_r.rem[15:0];
                    s_nxt.result = s_r.quo;
                    s_nxt.done = 1'b1;
                    s_nxt.st = ST_IDLE;
                end
            endcase
        end
        // Program counter and program-space access limit
        if (i_pc_load)
            s_nxt.pc = {i_pc_target[23:1], 1'b0};
        else if (i_pc_advance)
            s_nxt.pc = s_r.pc + PC_STEP;
        s_nxt.prog_ok = !i_prog_addr[23] || (i_table_op && s_r.table_page_register[TBL_CFG]);
        // Effective priority and user-interrupt masking
        s_nxt.prio = {s_nxt.priority_extension_bit, s_nxt.ipl};
        s_nxt.irq_off = s_nxt.priority_extension_bit || (s_nxt.ipl == IPL_MAX);
        // Busy kept as its own flop so the output carries no decode
        s_nxt.busy = (s_nxt.st != ST_IDLE);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.pc <= RST_PC;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    assign o_pready           = s_r.pready;
    assign o_prdata           = s_r.prdata;
    assign o_pslverr          = s_r.pslverr;
    assign o_busy             = s_r.busy;
    assign o_done             = s_r.done;
    assign o_result           = s_r.result;
    assign o_mem_we           = s_r.mem_we;
    assign o_mem_byte         = s_r.mem_byte;
    assign o_mem_wdata        = s_r.mem_wdata;
    assign o_cpu_priority     = s_r.prio;
    assign o_user_irq_disable = s_r.irq_off;
    assign o_psv_map_enable   = s_r.program_visibility_enable;
    assign o_pc               = s_r.pc;
    assign o_prog_access_ok   = s_r.prog_ok;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Divider age counter; a hold anywhere in the run voids the check
    logic [4:0] div_age;
    logic       div_held;
    always_ff @(posedge i_clk) begin
        if (i_srst || (i_op_valid && !o_busy && i_op == OP_DIV)) begin
            div_age <= 5'h01;
            div_held <= 1'b0;
        end else if (o_busy) begin
            div_age <= div_age + 5'h01;
            div_held <= div_held | i_div_hold;
        end
    end
    logic word_fire;
    assign word_fire = i_op_valid && !o_busy && !i_byte_mode && !i_src_mem && !i_use_lit;

    property p_half_carry;
        @(posedge i_clk) disable iff (i_srst)
        (word_fire && i_op == OP_ADD && !i_ipl_load) |=>
            s_r.dc == (({1'b0, $past(s_r.wreg[i_wa][7:0])} + {1'b0, $past(s_r.wreg[i_wb][7:0])}) > 9'h0ff);
    endproperty
    a_half_carry: assert property (p_half_carry) else $error("half carry wrong");

    property p_ipl_locked;
        @(posedge i_clk) disable iff (i_srst)
        (s_r.nest_dis && !i_ipl_load) |=> $stable(s_r.ipl);
    endproperty
    a_ipl_locked: assert property (p_ipl_locked) else $error("priority changed while locked");

    property p_ext_mask;
        @(posedge i_clk) disable iff (i_srst)
        s_r.priority_extension_bit |-> (o_user_irq_disable && o_cpu_priority[3]);
    endproperty
    a_ext_mask: assert property (p_ext_mask) else $error("extension not masking");

    property p_ext_set_only_hw;
        @(posedge i_clk) disable iff (i_srst)
        $rose(s_r.priority_extension_bit) |-> $past(i_priority_ext_set);
    endproperty
    a_ext_set_only_hw: assert property (p_ext_set_only_hw) else $error("extension set by software");

    property p_repeat_flag;
        @(posedge i_clk) disable iff (i_srst)
        i_repeat_active |=> flags_view[FLG_RA];
    endproperty
    a_repeat_flag: assert property (p_repeat_flag) else $error("repeat flag missing");

    property p_neg_zero;
        @(posedge i_clk) disable iff (i_srst)
        (word_fire && i_op inside {OP_AND, OP_IOR, OP_XOR} && !i_dst_mem) |=>
            (s_r.n == o_result[15]) && (s_r.z == (o_result == 16'h0000)) && o_done;
    endproperty
    a_neg_zero: assert property (p_neg_zero) else $error("N or Z wrong");

    property p_sub_flags;
        @(posedge i_clk) disable iff (i_srst)
        (word_fire && i_op == OP_SUB) |=>
            (s_r.c == ($past(s_r.wreg[i_wa]) >= $past(s_r.wreg[i_wb]))) &&
            (s_r.ov == (($past(s_r.wreg[i_wa][15]) != $past(s_r.wreg[i_wb][15])) &&
                        (o_result[15] != $past(s_r.wreg[i_wa][15]))));
    endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("borrow or overflow wrong");

    sequence s_div_start;
        i_op_valid && !o_busy && i_op == OP_DIV;
    endsequence
    property p_div_busy;
        @(posedge i_clk) disable iff (i_srst)
        s_div_start |=> o_busy [*8];
    endproperty
    a_div_busy: assert property (p_div_busy) else $error("divider left busy early");

    property p_div_time;
        @(posedge i_clk) disable iff (i_srst)
        (o_done && $past(o_busy) && !div_held) |-> (div_age == 5'(DIV_CYCLES));
    endproperty
    a_div_time: assert property (p_div_time) else $error("divide not nineteen cycles");

    property p_pc_step;
        @(posedge i_clk) disable iff (i_srst)
        (i_pc_advance && !i_pc_load) |=> (o_pc == $past(o_pc) + PC_STEP) && !o_pc[0];
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc step wrong");

    property p_prog_limit;
        @(posedge i_clk) disable iff (i_srst)
        (i_prog_addr[23] && !i_table_op) |=> !o_prog_access_ok;
    endproperty
    a_prog_limit: assert property (p_prog_limit) else $error("upper program space reached");
endmodule
`default_nettype wire

// ==== test_cpu_alu_status_datapath.sv ====
// Self-checking bench for the integer datapath over APB and op port
`default_nettype none
`define CHK(nm,e,g) begin n_compared++; if ((g)!==(e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h",nm,e,g); end end
module test_cpu_alu_status_datapath import alu_core_pkg::*; ;
timeunit 1ns;
timeprecision 1ps;
// ----------------------------------------
// Stimulus and observed signals
// ----------------------------------------
logic i_clk=0, i_srst=1, i_psel=0, i_penable=0, i_pwrite=0, er;
logic [11:0] i_paddr='0;
logic [31:0] i_pwdata='0, o_prdata, rd;
logic [3:0] i_pstrb=4'h3, i_wa='0, i_wb='0, i_wd='0, o_cpu_priority;
logic o_pready, o_pslverr, i_op_valid=0, i_byte_mode=0, i_src_mem=0, i_dst_mem=0;
op_t i_op=OP_ADD;
mul_mode_t i_mul_mode=MUL_UU;
logic i_use_lit=0, i_div_signed=0, i_div_long=0, i_div_hold=0, i_repeat_active=0;
logic [4:0] i_lit='0;
logic [15:0] i_mem_rdata='0, o_result, o_mem_wdata;
logic i_ipl_load=0, i_priority_ext_set=0, i_pc_advance=0, i_pc_load=0, i_table_op=0;
logic [2:0] i_ipl_value='0;
logic [23:0] i_pc_target='0, i_prog_addr='0, o_pc;
logic o_busy, o_done, o_mem_we, o_mem_byte, o_user_irq_disable, o_psv_map_enable;
logic o_prog_access_ok;
int mismatches=0, n_compared=0, cyc=0, n;
cpu_alu_status_datapath DUT (.*);
// Clock and a hang guard well above the 150 or so cycles needed
initial forever #5 i_clk = ~i_clk;
always @(posedge i_clk) if (++cyc == 5000) begin
    mismatches++;
    test_done();
end
task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
// APB transfer: request held until pready is sampled high at a rising edge
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk); i_psel <= 1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
    @(posedge i_clk); i_penable <= 1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata; er = o_pslverr;
    i_psel <= 0; i_penable <= 0;
endtask
// One operation; n counts cycles from the accept edge to done
task automatic op(input op_t o, input logic [3:0] a, b, d);
    @(posedge i_clk); i_op_valid <= 1; i_op <= o; i_wa <= a; i_wb <= b; i_wd <= d;
    @(posedge i_clk); i_op_valid <= 0;
    n = 0;
    do @(posedge i_clk) n++; while (o_done !== 1'b1 && n < 40);
endtask
initial begin
    repeat (10) @(posedge i_clk);
    i_srst <= 0;
    apb(0, OFF_FLAGS, 0); `CHK("flags", 32'h0, rd)
    apb(0, OFF_CORE_CTL, 0); `CHK("core", 32'h0, rd)
    apb(0, 12'h0f0, 0); `CHK("unmapped", 1'b1, er)
    $display("test reset done");
    apb(1, OFF_WREG_BASE+12'h008, 32'h7fff); apb(1, OFF_WREG_BASE+12'h00c, 32'h1);
    op(OP_ADD, 2, 3, 4); `CHK("add", 16'h8000, o_result)
    apb(0, OFF_FLAGS, 0); `CHK("add flags", 32'h10c, rd)
    op(OP_SUB, 3, 3, 5); apb(0, OFF_FLAGS, 0);
    `CHK("sub flags", 32'h103, rd)
    op(OP_AND, 2, 2, 6); apb(0, OFF_FLAGS, 0); `CHK("and flags", 32'h101, rd)
    i_use_lit <= 1; i_lit <= 5'h04;
    op(OP_ARS, 4, 0, 7); `CHK("ars", 16'hf800, o_result)
    op(OP_LRS, 4, 0, 7); `CHK("lrs", 16'h0800, o_result)
    op(OP_LSH, 2, 0, 7); `CHK("lsh", 16'hfff0, o_result)
    i_use_lit <= 0; i_mul_mode <= MUL_SS; i_dst_mem <= 1;
    op(OP_XOR, 2, 3, 0); `CHK("mem", 17'h17ffe, {o_mem_we, o_mem_wdata})
    i_dst_mem <= 0;
    op(OP_MUL, 4, 2, 8); `CHK("mul lo", 16'h8000, o_result)
    apb(0, OFF_WREG_BASE+12'h024, 0); `CHK("mul hi", 32'hc000, rd)
    apb(1, OFF_WREG_BASE+12'h008, 32'h64); apb(1, OFF_WREG_BASE+12'h00c, 32'h7);
    op(OP_DIV, 2, 3, 0); `CHK("div cycles", 19, n)
    apb(0, OFF_WREG_BASE, 0); `CHK("quot", 32'he, rd)
    apb(0, OFF_WREG_BASE+12'h004, 0); `CHK("rem", 32'h2, rd)
    $display("test alu done");
    apb(1, OFF_FLAGS, 32'hffff); apb(0, OFF_FLAGS, 0); `CHK("wr", 32'h1ef, rd)
    `CHK("prio", 4'h7, o_cpu_priority)
    apb(1, OFF_INT_CTL1, 32'h8000); apb(1, OFF_FLAGS, 0); apb(0, OFF_FLAGS, 0);
    `CHK("locked", 32'he0, rd)
    i_repeat_active <= 1; apb(0, OFF_FLAGS, 0); `CHK("ra", 32'hf0, rd)
    i_repeat_active <= 0;
    apb(1, OFF_CORE_CTL, 32'hc); apb(0, OFF_CORE_CTL, 0); `CHK("ctl", 32'h4, rd)
    `CHK("psv", 1'b1, o_psv_map_enable)
    @(posedge i_clk) i_priority_ext_set <= 1;
    @(posedge i_clk) i_priority_ext_set <= 0;
    apb(0, OFF_CORE_CTL, 0); `CHK("ext", 32'hc, rd)
    `CHK("prio4", 4'hf, o_cpu_priority)
    `CHK("irq off", 1'b1, o_user_irq_disable)
    apb(1, OFF_CORE_CTL, 0); apb(0, OFF_CORE_CTL, 0); `CHK("clr", 32'h0, rd)
    i_srst <= 1; repeat (2) @(posedge i_clk); i_srst <= 0;
    apb(0, OFF_FLAGS, 0); `CHK("reset flags", 32'h0, rd)
    $display("test regs done");
    @(posedge i_clk) begin i_pc_advance <= 1; i_prog_addr <= 24'h800000; end
    @(posedge i_clk) i_pc_advance <= 0;
    apb(0, OFF_PC, 0); `CHK("pc", 32'h2, rd)
    `CHK("upper", 1'b0, o_prog_access_ok)
    apb(1, OFF_TBL_PAGE, 32'h80); i_table_op <= 1; repeat (2) @(posedge i_clk);
    `CHK("table", 1'b1, o_prog_access_ok)
    $display("test pc done");
    test_done();
end
endmodule
`default_nettype wire
